// >>> rtl/ccrf_params.svh
// register offsets, field positions, reset values and timing constants of the control map
`ifndef CCRF_PARAMS_SVH
`define CCRF_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CCRF_OFS_INLIM 8'h00
`define CCRF_OFS_CTRL0 8'h01
`define CCRF_OFS_ICHG 8'h02

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CCRF_RST_INLIM 8'h17
`define CCRF_RST_CTRL0 8'h1a
`define CCRF_RST_ICHG 8'h91
`define CCRF_RD_UNMAPPED 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CCRF_INLIM_HIZ 7
`define CCRF_INLIM_CODE_HI 4
`define CCRF_CTRL0_PULSE_SKIP_DISABLE 7
`define CCRF_CTRL0_WD_KICK 6
`define CCRF_CTRL0_BOOST_EN 5
`define CCRF_CTRL0_CHG_EN 4
`define CCRF_CTRL0_SYSMIN_HI 3
`define CCRF_CTRL0_SYSMIN_LO 1
`define CCRF_CTRL0_BST_EXIT 0
`define CCRF_ICHG_CODE_HI 5

// ---------------------------------------------------------------
// input limit codes and scale
// ---------------------------------------------------------------
`define CCRF_INLIM_STEP_MA 12'h064
`define CCRF_INLIM_OFFSET_MA 12'h064
`define CCRF_INLIM_CODE_PSEL_HI 5'h04
`define CCRF_INLIM_CODE_PSEL_LO 5'h17

// ---------------------------------------------------------------
// minimum system voltage table in mV
// ---------------------------------------------------------------
`define CCRF_SYSMIN_0 12'ha28
`define CCRF_SYSMIN_1 12'haf0
`define CCRF_SYSMIN_2 12'hbb8
`define CCRF_SYSMIN_3 12'hc80
`define CCRF_SYSMIN_4 12'hd48
`define CCRF_SYSMIN_5 12'hdac
`define CCRF_SYSMIN_6 12'he10
`define CCRF_SYSMIN_7 12'he74

// ---------------------------------------------------------------
// watchdog interval
// ---------------------------------------------------------------
`define CCRF_CLK_HZ 40000000
`define CCRF_WD_TIME_S 40
`define CCRF_WD_CYCLES (`CCRF_WD_TIME_S * `CCRF_CLK_HZ)

`endif

// >>> rtl/ccrf_pkg.sv
// types shared by the charger control register block
package ccrf_pkg;

  // operating mode reported from the enable bits
  typedef enum logic [1:0] {
    CCRF_MODE_IDLE = 2'b00,
    CCRF_MODE_CHARGE = 2'b01,
    CCRF_MODE_BOOST = 2'b10
  } ccrf_mode_t;

  typedef logic [7:0] ccrf_byte_t;

endpackage

// >>> rtl/ccrf_regs.sv
// charger control register bank: input limit, control 0 and charge current registers
`timescale 1ns/1ps
`include "ccrf_params.svh"

// Notes on behaviour
// - input limit is weighted code plus 100 mA
// - input limit code defaults to 10111
// - detection done loads 500 mA or 2.4 A
// - host writes after detection take effect
// - bit 7 set disables pulse skipping
// - kick restarts watchdog, then self-clears
// - charge needs pin low, bit set, current nonzero
// - charge enable resets 1, boost 0
// - three-bit minimum system voltage table, reset 101
// - bit 0 selects boost exit battery floor
// - control register resets to 1a
// - charge current register resets to 91
// - high impedance bit idles buck, resets 0
module ccrf_regs #(
  parameter int WD_CYCLES = `CCRF_WD_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_reg_rst_req,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire ccrf_pkg::ccrf_byte_t i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_src_det_done,
  input wire logic i_psel,
  input wire logic i_ce_n,
  input wire logic i_adapter_present,
  output ccrf_pkg::ccrf_byte_t o_reg_rdata,
  output logic [11:0] o_inlim_ma,
  output logic o_hiz,
  output logic o_pfm_enable,
  output logic o_charge_allow,
  output logic o_boost_allow,
  output ccrf_pkg::ccrf_mode_t o_mode,
  output logic [11:0] o_sysmin_mv,
  output logic o_bst_exit_sel,
  output logic [5:0] o_ichg_code,
  output logic o_wd_expired
);
  import ccrf_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (WD_CYCLES < 2) begin : g_bad_wd
    $error("watchdog interval must be at least two cycles");
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  ccrf_byte_t inlim_ff, nxt_inlim;
  ccrf_byte_t ctrl0_ff, nxt_ctrl0;
  ccrf_byte_t ichg_ff, nxt_ichg;
  ccrf_byte_t rdata_ff, nxt_rdata;
  logic [31:0] wd_cnt_ff, nxt_wd_cnt;
  logic wd_exp_ff, nxt_wd_exp;
  logic wr_inlim, wr_ctrl0, wr_ichg, wd_fire;

  // watchdog reload value, narrowed once
  localparam logic [31:0] WD_LOAD = 32'(WD_CYCLES - 1);
  localparam ccrf_byte_t WD_MASK_CTRL0 = ccrf_byte_t'((1 << `CCRF_CTRL0_WD_KICK)
    | (1 << `CCRF_CTRL0_BOOST_EN) | (1 << `CCRF_CTRL0_CHG_EN));
  localparam ccrf_byte_t WD_MASK_ICHG = ccrf_byte_t'((1 << (`CCRF_ICHG_CODE_HI + 1)) - 1);
  localparam ccrf_byte_t WD_MASK_INLIM = ccrf_byte_t'(1 << `CCRF_INLIM_HIZ);

  assign wr_inlim = i_reg_wr && (i_reg_addr == `CCRF_OFS_INLIM);
  assign wr_ctrl0 = i_reg_wr && (i_reg_addr == `CCRF_OFS_CTRL0);
  assign wr_ichg = i_reg_wr && (i_reg_addr == `CCRF_OFS_ICHG);
  assign wd_fire = (wd_cnt_ff == 32'h0);

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------
  // priority: register reset, then watchdog restore, then detection, then host write
  always_comb begin
    nxt_inlim = inlim_ff;
    nxt_ctrl0 = ctrl0_ff;
    nxt_ichg = ichg_ff;
    // kick bit returns to 0 once the restart below has happened
    if (ctrl0_ff[`CCRF_CTRL0_WD_KICK]) begin
      nxt_ctrl0[`CCRF_CTRL0_WD_KICK] = 1'b0;
    end
    if (wr_inlim) begin
      nxt_inlim = i_reg_wdata;
    end
    if (wr_ctrl0) begin
      nxt_ctrl0 = i_reg_wdata;
    end
    if (wr_ichg) begin
      nxt_ichg = i_reg_wdata;
    end
    // detection result overrides a same-cycle host write of the code
    if (i_src_det_done) begin
      nxt_inlim[`CCRF_INLIM_CODE_HI:0] = i_psel ? `CCRF_INLIM_CODE_PSEL_HI
                                                : `CCRF_INLIM_CODE_PSEL_LO;
    end
    // expiry touches only the fields that follow the watchdog
    if (wd_fire) begin
      nxt_ctrl0 = (nxt_ctrl0 & ~WD_MASK_CTRL0) | (`CCRF_RST_CTRL0 & WD_MASK_CTRL0);
      nxt_ichg = (nxt_ichg & ~WD_MASK_ICHG) | (`CCRF_RST_ICHG & WD_MASK_ICHG);
      nxt_inlim = (nxt_inlim & ~WD_MASK_INLIM) | (`CCRF_RST_INLIM & WD_MASK_INLIM);
    end
    if (i_reg_rst_req) begin
      nxt_inlim = `CCRF_RST_INLIM;
      nxt_ctrl0 = `CCRF_RST_CTRL0;
      nxt_ichg = `CCRF_RST_ICHG;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && !i_nrst) begin // a frozen block ignores reset as well
      inlim_ff <= `CCRF_RST_INLIM;
      ctrl0_ff <= `CCRF_RST_CTRL0;
      ichg_ff <= `CCRF_RST_ICHG;
    end else if (i_clk_en) begin
      inlim_ff <= nxt_inlim;
      ctrl0_ff <= nxt_ctrl0;
      ichg_ff <= nxt_ichg;
    end
  end

  // ---------------------------------------------------------------
  // watchdog timer
  // ---------------------------------------------------------------
  // counts down; the host keeps it alive by kicking in time
  always_comb begin
    nxt_wd_cnt = wd_cnt_ff - 32'h1;
    nxt_wd_exp = wd_fire;
    if (ctrl0_ff[`CCRF_CTRL0_WD_KICK] || wd_fire || i_reg_rst_req) begin
      nxt_wd_cnt = WD_LOAD;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && !i_nrst) begin
      wd_cnt_ff <= WD_LOAD;
      wd_exp_ff <= 1'b0;
    end else if (i_clk_en) begin
      wd_cnt_ff <= nxt_wd_cnt;
      wd_exp_ff <= nxt_wd_exp;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // data registered one cycle after the read strobe, held until the next one
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `CCRF_OFS_INLIM: nxt_rdata = inlim_ff;
        `CCRF_OFS_CTRL0: nxt_rdata = ctrl0_ff;
        `CCRF_OFS_ICHG: nxt_rdata = ichg_ff;
        default: nxt_rdata = `CCRF_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && !i_nrst) begin
      rdata_ff <= `CCRF_RD_UNMAPPED;
    end else if (i_clk_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  logic [11:0] inlim_ma_ff, nxt_inlim_ma;
  logic [11:0] sysmin_ff, nxt_sysmin;
  logic hiz_ff, nxt_hiz, pfm_ff, nxt_pfm, chg_ff, nxt_chg, bst_ff, nxt_bst;
  logic bexit_ff, nxt_bexit;
  logic [5:0] ichg_code_ff, nxt_ichg_code;
  ccrf_mode_t mode_ff, nxt_mode;
  logic chg_bit, bst_bit;

  assign chg_bit = ctrl0_ff[`CCRF_CTRL0_CHG_EN];
  assign bst_bit = ctrl0_ff[`CCRF_CTRL0_BOOST_EN];

  // decoded from the registered fields, so outputs trail a write by two cycles
  always_comb begin
    // weights 1600..100 mA are exactly code times the step; a ceiling, not a typical
    nxt_inlim_ma = 12'(inlim_ff[`CCRF_INLIM_CODE_HI:0] * `CCRF_INLIM_STEP_MA)
                   + `CCRF_INLIM_OFFSET_MA;
    nxt_hiz = inlim_ff[`CCRF_INLIM_HIZ];
    nxt_pfm = ~ctrl0_ff[`CCRF_CTRL0_PULSE_SKIP_DISABLE];
    nxt_ichg_code = ichg_ff[`CCRF_ICHG_CODE_HI:0];
    nxt_chg = ~i_ce_n && chg_bit && (nxt_ichg_code != 6'h00);
    nxt_bst = bst_bit;
    nxt_bexit = ctrl0_ff[`CCRF_CTRL0_BST_EXIT];
    unique case (ctrl0_ff[`CCRF_CTRL0_SYSMIN_HI:`CCRF_CTRL0_SYSMIN_LO])
      3'h0: nxt_sysmin = `CCRF_SYSMIN_0;
      3'h1: nxt_sysmin = `CCRF_SYSMIN_1;
      3'h2: nxt_sysmin = `CCRF_SYSMIN_2;
      3'h3: nxt_sysmin = `CCRF_SYSMIN_3;
      3'h4: nxt_sysmin = `CCRF_SYSMIN_4;
      3'h5: nxt_sysmin = `CCRF_SYSMIN_5;
      3'h6: nxt_sysmin = `CCRF_SYSMIN_6;
      3'h7: nxt_sysmin = `CCRF_SYSMIN_7;
    endcase
    // with both enables set, boost when the adapter is absent, charge when it is present and charging is allowed
    nxt_mode = CCRF_MODE_IDLE;
    if (i_adapter_present && nxt_chg) begin
      nxt_mode = CCRF_MODE_CHARGE;
    end else if (!i_adapter_present && bst_bit) begin
      nxt_mode = CCRF_MODE_BOOST;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && !i_nrst) begin
      inlim_ma_ff <= 12'h000;
      hiz_ff <= 1'b0;
      pfm_ff <= 1'b0;
      chg_ff <= 1'b0;
      bst_ff <= 1'b0;
      bexit_ff <= 1'b0;
      ichg_code_ff <= 6'h00;
      sysmin_ff <= 12'h000;
      mode_ff <= CCRF_MODE_IDLE;
    end else if (i_clk_en) begin
      inlim_ma_ff <= nxt_inlim_ma;
      hiz_ff <= nxt_hiz;
      pfm_ff <= nxt_pfm;
      chg_ff <= nxt_chg;
      bst_ff <= nxt_bst;
      bexit_ff <= nxt_bexit;
      ichg_code_ff <= nxt_ichg_code;
      sysmin_ff <= nxt_sysmin;
      mode_ff <= nxt_mode;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_reg_rdata = rdata_ff;
  assign o_inlim_ma = inlim_ma_ff;
  assign o_hiz = hiz_ff;
  assign o_pfm_enable = pfm_ff;
  assign o_charge_allow = chg_ff;
  assign o_boost_allow = bst_ff;
  assign o_mode = mode_ff;
  assign o_sysmin_mv = sysmin_ff;
  assign o_bst_exit_sel = bexit_ff;
  assign o_ichg_code = ichg_code_ff;
  assign o_wd_expired = wd_exp_ff;

endmodule

// >>> testbench/ccrf_regs_chk.sv
// assertion checker for the charger control register block
`timescale 1ns/1ps
module ccrf_regs_chk (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_reg_rst_req,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire ccrf_pkg::ccrf_byte_t i_reg_wdata,
  input wire logic i_src_det_done,
  input wire logic i_psel,
  input wire logic i_ce_n,
  input wire logic i_adapter_present,
  input wire logic [11:0] o_inlim_ma,
  input wire logic o_hiz,
  input wire logic o_pfm_enable,
  input wire logic o_charge_allow,
  input wire logic o_boost_allow,
  input wire ccrf_pkg::ccrf_mode_t o_mode,
  input wire logic o_bst_exit_sel,
  input wire logic [5:0] o_ichg_code,
  input wire logic o_wd_expired
);
  import ccrf_pkg::*;
  // ---------------------------------------------------------------
  // decoded outputs against the writes, pins and watchdog that cause them
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  // a frozen pipeline breaks the fixed two-cycle latency, so pauses disable checks
  default disable iff (!i_nrst || !i_clk_en);
  a_inlim_write: assert property (i_reg_wr && i_reg_addr == 8'h00
    && !i_src_det_done && !i_reg_rst_req
    |-> ##2 o_inlim_ma == 12'($past(i_reg_wdata[4:0], 2)) * 12'h064 + 12'h064)
    else $error("input limit not decoded from written code");
  // an expiry in the write cycle clears the bit, and shows as a pulse one cycle on
  a_hiz_write: assert property (i_reg_wr && i_reg_addr == 8'h00 && !i_reg_rst_req
    |-> ##2 o_hiz == ($past(i_reg_wdata[7], 2) && !$past(o_wd_expired)))
    else $error("hiz does not follow bit 7");
  a_det_load: assert property (i_src_det_done && !i_reg_rst_req
    |-> ##2 o_inlim_ma == ($past(i_psel, 2) ? 12'h1f4 : 12'h960)) else $error("detection load");
  a_pfm_ctrl: assert property (i_reg_wr && i_reg_addr == 8'h01 && !i_reg_rst_req
    |-> ##2 o_pfm_enable == !$past(i_reg_wdata[7], 2)) else $error("pfm enable mismatch");
  a_exit_sel: assert property (i_reg_wr && i_reg_addr == 8'h01 && !i_reg_rst_req
    |-> ##2 o_bst_exit_sel == $past(i_reg_wdata[0], 2)) else $error("exit select mismatch");
  a_charge_gate: assert property ($past(i_ce_n) |-> !o_charge_allow)
    else $error("charge allowed with pin high");
  a_mode_boost: assert property (o_mode == CCRF_MODE_BOOST
    |-> o_boost_allow && !$past(i_adapter_present)) else $error("boost mode without cause");
  a_wd_defaults: assert property (o_wd_expired
    |=> !o_boost_allow && !o_hiz && o_ichg_code == 6'h11) else $error("expiry defaults");
endmodule
bind ccrf_regs ccrf_regs_chk i_chk (.*);

// >>> testbench/ccrf_host.sv
// host model: single-byte register accesses on the byte port
`timescale 1ns/1ps
module ccrf_host (
  input wire logic i_clk_sys,
  input wire ccrf_pkg::ccrf_byte_t i_rdata,
  output logic [7:0] o_addr,
  output ccrf_pkg::ccrf_byte_t o_wdata,
  output logic o_wr,
  output logic o_rd
);
  import ccrf_pkg::*;
  // ---------------------------------------------------------------
  // access task
  // ---------------------------------------------------------------
  // idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'h0;
    o_rd = 1'h0;
  end
  // strobe held up to the taking edge; idle lines show inverted bytes, not stale ones
  task automatic xfer(input logic w, input logic [7:0] a, input ccrf_byte_t d,
                      output ccrf_byte_t q);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_clk_sys);
    o_wr <= 1'h0;
    o_rd <= 1'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    q = i_rdata;
  endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the charger control register block
`timescale 1ns/1ps
module tb;
  import ccrf_pkg::*;
  // ---------------------------------------------------------------
  // signals, models and helpers
  // ---------------------------------------------------------------
  logic i_clk_sys = 1'h0, i_nrst = 1'h0, i_clk_en = 1'h1, i_reg_rst_req = 1'h0;
  logic i_src_det_done = 1'h0, i_psel = 1'h0, i_ce_n = 1'h0, i_adapter_present = 1'h1;
  logic i_reg_wr, i_reg_rd, o_hiz, o_pfm_enable, o_charge_allow, o_boost_allow;
  logic o_bst_exit_sel, o_wd_expired;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd_val;
  logic [11:0] o_inlim_ma, o_sysmin_mv;
  logic [5:0] o_ichg_code;
  ccrf_mode_t o_mode;
  int num_errors = 0, check_count = 0, wd_seen = 0;
  logic [4:0] codes [3] = '{5'h00, 5'h1f, 5'h0a};
  logic [11:0] sm [8] = '{12'ha28, 12'haf0, 12'hbb8, 12'hc80, 12'hd48, 12'hdac, 12'he10, 12'he74};
  // short watchdog so expiry fits the run
  ccrf_regs #(.WD_CYCLES(200)) i_dut (.*);
  ccrf_host i_host (.i_clk_sys, .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
                    .o_wdata(i_reg_wdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd));
  always #12.5 i_clk_sys = ~i_clk_sys;
  // count expiry pulses
  always @(posedge i_clk_sys) if (o_wd_expired === 1'h1) wd_seen <= wd_seen + 1;
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write, then wait until decoded outputs show it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(1'h1, a, d, rd_val);
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.xfer(1'h0, a, 8'h00, rd_val);
    chk("read", {4'h0, e}, {4'h0, rd_val});
  endtask
  // pin levels plus one-cycle detection / register-reset pulses
  task automatic pins(input logic det, input logic ps, input logic ad, input logic ce,
                      input logic rr);
    @(posedge i_clk_sys);
    i_src_det_done <= det;
    i_psel <= ps;
    i_adapter_present <= ad;
    i_ce_n <= ce;
    i_reg_rst_req <= rr;
    @(posedge i_clk_sys);
    i_src_det_done <= 1'h0;
    i_reg_rst_req <= 1'h0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, about six times the expected run
  initial begin
    #50us;
    num_errors++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("limit", 12'h960, o_inlim_ma);
    chk("sysmin", 12'hdac, o_sysmin_mv);
    chk("boost", 12'h0, 12'(o_boost_allow));
    chk("ichg", 12'h011, 12'(o_ichg_code));
    rd_chk(8'h00, 8'h17);
    rd_chk(8'h01, 8'h1a);
    rd_chk(8'h02, 8'h91);
    rd_chk(8'h07, 8'h00);
    foreach (codes[k]) begin
      wr(8'h00, {k[0], 2'h0, codes[k]});
      chk("limit", 12'(codes[k]) * 12'h064 + 12'h064, o_inlim_ma);
      chk("hiz", 12'(k[0]), 12'(o_hiz));
    end
    pins(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    chk("limit", 12'h1f4, o_inlim_ma);
    pins(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    chk("limit", 12'h960, o_inlim_ma);
    wr(8'h00, 8'h02);
    chk("limit", 12'h12c, o_inlim_ma);
    // every control write here also kicks the watchdog
    for (int s = 0; s < 8; s++) begin
      wr(8'h01, {s[0], 3'h5, s[2:0], s[0]});
      chk("pfm", 12'(!s[0]), 12'(o_pfm_enable));
      chk("exit sel", 12'(s[0]), 12'(o_bst_exit_sel));
      chk("sysmin", sm[s], o_sysmin_mv);
    end
    rd_chk(8'h01, 8'h9f);
    wr(8'h02, 8'h00);
    chk("charge", 12'h0, 12'(o_charge_allow));
    wr(8'h02, 8'h91);
    chk("charge", 12'h1, 12'(o_charge_allow));
    chk("mode", 12'h1, 12'(o_mode));
    pins(1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    chk("charge", 12'h0, 12'(o_charge_allow));
    wr(8'h01, 8'h6a);
    pins(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    chk("charge", 12'h0, 12'(o_charge_allow));
    chk("mode", 12'h2, 12'(o_mode));
    chk("boost", 12'h1, 12'(o_boost_allow));
    wr(8'h01, 8'h7a);
    pins(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    chk("mode", 12'h1, 12'(o_mode));
    chk("expiries", 12'h0, 12'(wd_seen));
    // stop kicking and let the watchdog run out
    wr(8'h00, 8'h85);
    wr(8'h02, 8'h3f);
    wr(8'h01, 8'h2a);
    for (int n = 0; n < 300 && wd_seen == 0; n++) @(posedge i_clk_sys);
    #1;
    chk("expiries", 12'h1, 12'(wd_seen));
    rd_chk(8'h01, 8'h1a);
    rd_chk(8'h00, 8'h05);
    rd_chk(8'h02, 8'h11);
    pins(1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    rd_chk(8'h00, 8'h17);
    // a write while the enable is low must leave the defaults alone
    @(posedge i_clk_sys);
    i_clk_en <= 1'h0;
    wr(8'h00, 8'h9f);
    @(posedge i_clk_sys);
    i_clk_en <= 1'h1;
    rd_chk(8'h00, 8'h17);
    chk("limit", 12'h960, o_inlim_ma);
    wrap_up();
  end
endmodule
